// *** core/rbrm_pkg.sv ***
// Shared constants for the receive buffer ring manager.
// Assumes a 32-bit AXI4-Lite register bus and byte-wide local buffer RAM.
package rbrm_pkg;
	////////////////////////////////////////////////////////////////////////
	// Register byte offsets
	localparam logic [7:0] REG_CMD = 8'h00;
	localparam logic [7:0] REG_FIRST = 8'h04;
	localparam logic [7:0] REG_END = 8'h08;
	localparam logic [7:0] REG_BNDRY = 8'h0C;
	localparam logic [7:0] REG_CURR = 8'h10;
	localparam logic [7:0] REG_EVENT = 8'h14;
	localparam logic [7:0] REG_RXCFG = 8'h18;
	localparam logic [7:0] REG_TXCFG = 8'h1C;
	localparam logic [7:0] REG_DMA_HI = 8'h20;
	localparam logic [7:0] REG_DMA_LO = 8'h24;
	localparam logic [7:0] REG_MISSED = 8'h28;
	localparam logic [7:0] REG_RCNT_LO = 8'h2C;
	localparam logic [7:0] REG_RCNT_HI = 8'h30;
	////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int CMD_HALT = 0;
	localparam int CMD_START = 1;
	localparam int CMD_TX_GO = 2;
	localparam int EV_RX_OK = 0;
	localparam int EV_FRAME_SENT = 1;
	localparam int EV_RX_ERR = 2;
	localparam int EV_OVF = 4;
	localparam int EV_HALTED = 7;
	localparam int RXCFG_ACC_ERR = 0;
	localparam int RXCFG_ACC_RUNT = 1;
	localparam int TXCFG_LB_LO = 1;
	localparam int TXCFG_LB_HI = 2;
	////////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic RST_HALTED = 1'b1;
	localparam logic [7:0] RST_PAGE = 8'h00;
	localparam logic [7:0] RST_CFG = 8'h00;
	localparam logic [7:0] RST_EVENT = 8'h00;
	////////////////////////////////////////////////////////////////////////
	// Frame and check value constants
	localparam logic [7:0] HDR_BYTES = 8'h04;
	localparam logic [7:0] PAGE_LAST = 8'hFF;
	localparam logic [15:0] RUNT_MIN = 16'h0040;
	localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
	localparam logic [31:0] CRC_POLY = 32'hEDB88320;
	localparam logic [31:0] CRC_RESIDUE = 32'hDEBB20E3;
	localparam logic [1:0] FCS_LAST = 2'h3;
	localparam logic [1:0] LB_NONE = 2'h0;
	localparam logic [1:0] AXI_OKAY = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;
	////////////////////////////////////////////////////////////////////////
	typedef enum logic [1:0] {RX_IDLE, RX_DATA, RX_DROP, RX_HDR} rbrm_rx_state_t;
	typedef enum logic {TX_PASS, TX_FCS} rbrm_tx_state_t;
endpackage : rbrm_pkg

// *** core/rbrm_crc32.sv ***
// Byte-wide 32-bit frame check generator, LSB first.
// Assumes the caller presents one byte per enabled cycle.
`timescale 1ns/10ps
`default_nettype none
module rbrm_crc32 import rbrm_pkg::*; (
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire logic i_en,
	input wire logic i_init,
	input wire logic [7:0] i_data,
	output logic [31:0] o_next,
	output logic [31:0] o_crc
);
	logic [31:0] c;
	logic fb;

	always_comb begin
		c = i_init ? CRC_INIT : o_crc;
		fb = 1'b0;
		for (int k = 0; k < 8; k++) begin
			fb = c[0] ^ i_data[k];
			c = {1'b0, c[31:1]} ^ (fb ? CRC_POLY : 32'h00000000);
		end
		o_next = c;
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_crc <= CRC_INIT;
		end else if (i_en) begin
			o_crc <= o_next;
		end
	end
endmodule : rbrm_crc32
`default_nettype wire

// *** core/rbrm_page_step.sv ***
// Next ring page; a step onto the end page wraps back to the first page.
// Purely combinational; pages are address bits 15..8.
`timescale 1ns/10ps
`default_nettype none
module rbrm_page_step (
	input wire logic [7:0] i_page,
	input wire logic [7:0] i_first,
	input wire logic [7:0] i_end,
	output logic [7:0] o_next
);
	logic [7:0] inc;

	assign inc = i_page + 8'h01;
	assign o_next = (inc == i_end) ? i_first : inc;
endmodule : rbrm_page_step
`default_nettype wire

// *** core/rbrm_ring_manager.sv ***
// Receive buffer ring manager with frame check and AXI4-Lite registers.
// Assumes rx and tx byte streams come from MAC logic on the same clock.
// Function
// [RULE1] Source address and length/type bytes go to memory unchanged.
// [RULE2] No pad insertion or removal, no oversize check.
// [RULE3] Append 32-bit frame check value to every transmitted frame.
// [RULE4] Reject received frames whose check generator misses the residue.
// [RULE5] Frames stored in 256-byte pages within 64k local space.
// [RULE6] Pages from first to end page form a ring; end wraps to first.
// [RULE7] Current page marks first page of frame being received.
// [RULE8] Abort reception when the write address reaches the boundary page.
// [RULE9] Host loads first page into current and boundary before use.
// [RULE10] Host never programs the first ring page as zero.
// [RULE11] Storage starts at current page, first 4 bytes kept for header.
// [RULE12] Link strictly to the following page; long frames span six.
// [RULE13] Next page checked against end page, then boundary, then linked.
// [RULE14] Overflow sets the warning flag and keeps stored frames intact.
// [RULE15] After overflow reception stays suspended until recovery.
// [RULE16] Host saves transmit-go bit then writes 21H to stop.
// [RULE17] Stop lets a frame in progress finish; host waits 1.6 ms.
// [RULE18] Host clears both remote count registers before restart.
// [RULE19] Host resends only if go was set and no sent/error flag.
// [RULE20] Host enters loopback 1 or 2, then restarts with 22H.
// [RULE21] Host clears overflow flag after draining, then leaves loopback.
// [RULE22] Host reissues transmission with 26H when resend is marked.
// [RULE23] Missed-frame tally does not count while stopped.
// [RULE24] Good frame: header at first page, next frame on next page.
// [RULE25] Rejected frame: write address reset to current page.
// [RULE26] Received check bytes stored right after the last data byte.
// [RULE27] Page register supplies address bits 15..8, low byte zero.
`timescale 1ns/10ps
`default_nettype none
module rbrm_ring_manager import rbrm_pkg::*; #(
	parameter int AXI_AW = 8
) (
	input wire logic I_CLK_SYS,
	input wire logic I_ARST_N,
	input wire logic I_AXI_AWVALID,
	output logic O_AXI_AWREADY,
	input wire logic [AXI_AW-1:0] I_AXI_AWADDR,
	input wire logic I_AXI_WVALID,
	output logic O_AXI_WREADY,
	input wire logic [31:0] I_AXI_WDATA,
	input wire logic [3:0] I_AXI_WSTRB,
	output logic O_AXI_BVALID,
	input wire logic I_AXI_BREADY,
	output logic [1:0] O_AXI_BRESP,
	input wire logic I_AXI_ARVALID,
	output logic O_AXI_ARREADY,
	input wire logic [AXI_AW-1:0] I_AXI_ARADDR,
	output logic O_AXI_RVALID,
	input wire logic I_AXI_RREADY,
	output logic [31:0] O_AXI_RDATA,
	output logic [1:0] O_AXI_RRESP,
	input wire logic I_RX_VALID,
	input wire logic I_RX_SOF,
	input wire logic I_RX_LAST,
	input wire logic I_RX_ALIGN_ERR,
	input wire logic [7:0] I_RX_DATA,
	output logic O_MEM_WE,
	output logic [15:0] O_MEM_ADDR,
	output logic [7:0] O_MEM_WDATA,
	input wire logic I_TX_VALID,
	input wire logic I_TX_LAST,
	input wire logic [7:0] I_TX_DATA,
	output logic O_TX_READY,
	output logic O_TX_VALID,
	output logic O_TX_LAST,
	output logic [7:0] O_TX_DATA,
	input wire logic I_TX_OUT_READY
);
	logic aw_held, w_held, wr_fire, wr_en, mapped_w, mapped_r;
	logic [AXI_AW-1:0] aw_addr;
	logic [7:0] w_byte, rd_byte;
	logic halted, tx_go, ovf_lock, tx_done, rx_open;
	logic [7:0] ring_first_page, ring_end_page, bndry, curr, rxcfg, txcfg;
	logic [7:0] remote_count_low, remote_count_high, missed, event_status_reg;
	logic [7:0] ev_set, ev_clr, link_page, next_page, status;
	rbrm_rx_state_t rx_state;
	rbrm_tx_state_t tx_state;
	logic [15:0] dma, wr_addr, byte_cnt, cnt_now;
	logic [1:0] hdr_idx, fcs_idx;
	logic rx_take, ev_ok, ev_err, ev_ovf, ev_miss, crc_bad, runt, reject;
	logic [31:0] rx_next, rx_crc, tx_crc, fcs;
	logic tx_take, tx_first, out_free;

	////////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave: address and data taken in either order
	assign O_AXI_AWREADY = !aw_held;
	assign O_AXI_WREADY = !w_held;
	assign O_AXI_ARREADY = !O_AXI_RVALID;
	assign wr_fire = aw_held && w_held && !O_AXI_BVALID;
	assign wr_en = wr_fire && mapped_w;

	always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= '0;
			w_byte <= 8'h00;
			O_AXI_BVALID <= 1'b0;
			O_AXI_BRESP <= AXI_OKAY;
		end else begin
			if (I_AXI_AWVALID && !aw_held) begin
				aw_held <= 1'b1;
				aw_addr <= I_AXI_AWADDR;
			end
			if (I_AXI_WVALID && !w_held) begin
				w_held <= 1'b1;
				// Registers are a byte wide; lane 0 alone carries them
				w_byte <= I_AXI_WSTRB[0] ? I_AXI_WDATA[7:0] : 8'h00;
			end
			if (wr_fire) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				O_AXI_BVALID <= 1'b1;
				O_AXI_BRESP <= mapped_w ? AXI_OKAY : AXI_SLVERR;
			end else if (O_AXI_BVALID && I_AXI_BREADY) begin
				O_AXI_BVALID <= 1'b0;
			end
		end
	end

	always_comb begin
		mapped_w = 1'b1;
		case (aw_addr[7:0])
			REG_CMD, REG_FIRST, REG_END, REG_BNDRY, REG_CURR, REG_EVENT,
			REG_RXCFG, REG_TXCFG, REG_RCNT_LO, REG_RCNT_HI: mapped_w = 1'b1;
			default: mapped_w = 1'b0;
		endcase
	end

	always_comb begin
		mapped_r = 1'b1;
		rd_byte = 8'h00;
		case (I_AXI_ARADDR[7:0])
			REG_CMD: rd_byte = {5'h00, tx_go, !halted, halted};
			REG_FIRST: rd_byte = ring_first_page;
			REG_END: rd_byte = ring_end_page;
			REG_BNDRY: rd_byte = bndry;
			REG_CURR: rd_byte = curr;
			REG_EVENT: rd_byte = event_status_reg
				| {halted && rx_state == RX_IDLE, 7'h00};
			REG_RXCFG: rd_byte = rxcfg;
			REG_TXCFG: rd_byte = txcfg;
			REG_DMA_HI: rd_byte = dma[15:8];
			REG_DMA_LO: rd_byte = dma[7:0];
			REG_MISSED: rd_byte = missed;
			REG_RCNT_LO: rd_byte = remote_count_low;
			REG_RCNT_HI: rd_byte = remote_count_high;
			default: mapped_r = 1'b0;
		endcase
	end

	always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			O_AXI_RVALID <= 1'b0;
			O_AXI_RDATA <= 32'h00000000;
			O_AXI_RRESP <= AXI_OKAY;
		end else if (I_AXI_ARVALID && !O_AXI_RVALID) begin
			O_AXI_RVALID <= 1'b1;
			O_AXI_RDATA <= {24'h000000, rd_byte};
			O_AXI_RRESP <= mapped_r ? AXI_OKAY : AXI_SLVERR;
		end else if (I_AXI_RREADY) begin
			O_AXI_RVALID <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Software registers
	always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			ring_first_page <= RST_PAGE;
			ring_end_page <= RST_PAGE;
			bndry <= RST_PAGE;
			rxcfg <= RST_CFG;
			txcfg <= RST_CFG;
			remote_count_low <= RST_CFG;
			remote_count_high <= RST_CFG;
		end else if (wr_en) begin
			case (aw_addr[7:0])
				REG_FIRST: ring_first_page <= w_byte;
				REG_END: ring_end_page <= w_byte;
				REG_BNDRY: bndry <= w_byte;
				REG_RXCFG: rxcfg <= w_byte;
				REG_TXCFG: txcfg <= w_byte;
				REG_RCNT_LO: remote_count_low <= w_byte;
				REG_RCNT_HI: remote_count_high <= w_byte;
				default: ;
			endcase
		end
	end

	// Stop wins over start when both bits are written together
	always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			halted <= RST_HALTED;
			tx_go <= 1'b0;
		end else begin
			if (wr_en && aw_addr[7:0] == REG_CMD && w_byte[CMD_HALT]) begin
				halted <= 1'b1;
			end else if (wr_en && aw_addr[7:0] == REG_CMD && w_byte[CMD_START]) begin
				halted <= 1'b0;
			end
			if (wr_en && aw_addr[7:0] == REG_CMD && w_byte[CMD_TX_GO]) begin
				tx_go <= 1'b1;
			end else if (tx_done) begin
				tx_go <= 1'b0;
			end
		end
	end

	// Hardware advance of the current page wins over a software write
	always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			curr <= RST_PAGE;
		end else if (ev_ok) begin
			curr <= next_page; // [RULE24]
		end else if (wr_en && aw_addr[7:0] == REG_CURR) begin
			curr <= w_byte;
		end
	end

	// Write one to clear; a set in the same cycle wins
	assign ev_set = {3'h0, ev_ovf, 1'b0, ev_err, tx_done, ev_ok};
	assign ev_clr = (wr_en && aw_addr[7:0] == REG_EVENT) ? w_byte : 8'h00;

	always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			event_status_reg <= RST_EVENT;
		end else begin
			event_status_reg <= (event_status_reg & ~ev_clr & 8'h7F) | ev_set; // [RULE14]
		end
	end

	// Suspension after overflow lasts until the stop command
	always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			ovf_lock <= 1'b0;
		end else if (ev_ovf) begin
			ovf_lock <= 1'b1; // [RULE15]
		end else if (halted) begin
			ovf_lock <= 1'b0;
		end
	end

	always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			missed <= 8'h00;
		end else if (ev_miss && !halted && missed != 8'hFF) begin
			missed <= missed + 8'h01; // [RULE23]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Receive path into the page ring
	assign rx_open = !halted && !ovf_lock && txcfg[TXCFG_LB_HI:TXCFG_LB_LO] == LB_NONE;
	assign rx_take = I_RX_VALID && (rx_state == RX_DATA
		|| (rx_state == RX_IDLE && I_RX_SOF && rx_open));
	assign wr_addr = (rx_state == RX_IDLE) ? {curr, HDR_BYTES} : dma; // [RULE11] [RULE27]
	assign cnt_now = (rx_state == RX_IDLE) ? 16'h0001 : byte_cnt + 16'h0001;
	assign crc_bad = rx_next != CRC_RESIDUE; // [RULE4]
	assign runt = cnt_now < RUNT_MIN;
	assign reject = ((crc_bad || I_RX_ALIGN_ERR) && !rxcfg[RXCFG_ACC_ERR])
		|| (runt && !rxcfg[RXCFG_ACC_RUNT]);
	assign ev_err = rx_take && I_RX_LAST && reject;
	assign ev_ovf = rx_take && !I_RX_LAST && wr_addr[7:0] == PAGE_LAST
		&& link_page == bndry; // [RULE8] [RULE13]
	assign ev_miss = rx_state == RX_IDLE && I_RX_VALID && I_RX_SOF && !rx_open;
	assign ev_ok = rx_state == RX_HDR && hdr_idx == FCS_LAST;

	rbrm_page_step u_link (
		.i_page(wr_addr[15:8]),
		.i_first(ring_first_page),
		.i_end(ring_end_page),
		.o_next(link_page)
	);

	rbrm_crc32 u_rx_crc (
		.i_clk(I_CLK_SYS),
		.i_arst_n(I_ARST_N),
		.i_en(rx_take),
		.i_init(rx_state == RX_IDLE),
		.i_data(I_RX_DATA),
		.o_next(rx_next),
		.o_crc(rx_crc)
	);

	always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			rx_state <= RX_IDLE;
			dma <= 16'h0000;
			byte_cnt <= 16'h0000;
			hdr_idx <= 2'h0;
			next_page <= RST_PAGE;
			status <= 8'h00;
			O_MEM_WE <= 1'b0;
			O_MEM_ADDR <= 16'h0000;
			O_MEM_WDATA <= 8'h00;
		end else begin
			O_MEM_WE <= 1'b0;
			case (rx_state)
				RX_IDLE, RX_DATA: begin
					if (rx_take) begin
						// Every byte, check bytes included, lands as received
						O_MEM_WE <= 1'b1; // [RULE1] [RULE2] [RULE26]
						O_MEM_ADDR <= wr_addr; // [RULE5]
						O_MEM_WDATA <= I_RX_DATA;
						dma <= wr_addr + 16'h0001;
						byte_cnt <= cnt_now;
						rx_state <= RX_DATA;
						if (I_RX_LAST) begin
							next_page <= link_page;
							status <= {4'h0, runt, I_RX_ALIGN_ERR, crc_bad,
								!(runt || I_RX_ALIGN_ERR || crc_bad)};
							hdr_idx <= 2'h0;
							rx_state <= reject ? RX_IDLE : RX_HDR;
							if (reject) begin
								dma <= {curr, 8'h00}; // [RULE25] [RULE7]
							end
						end else if (wr_addr[7:0] == PAGE_LAST) begin
							if (link_page == bndry) begin
								// Stored frames stay intact; rest of frame dropped
								dma <= {curr, 8'h00}; // [RULE8] [RULE14]
								rx_state <= RX_DROP;
							end else begin
								dma <= {link_page, 8'h00}; // [RULE6] [RULE12] [RULE13]
							end
						end
					end else if (ev_miss && !I_RX_LAST) begin
						rx_state <= RX_DROP;
					end
				end
				RX_DROP: begin
					if (I_RX_VALID && I_RX_LAST) begin
						rx_state <= RX_IDLE;
					end
				end
				RX_HDR: begin
					O_MEM_WE <= 1'b1;
					O_MEM_ADDR <= {curr, 6'h00, hdr_idx}; // [RULE7]
					case (hdr_idx)
						2'h0: O_MEM_WDATA <= status;
						2'h1: O_MEM_WDATA <= next_page;
						2'h2: O_MEM_WDATA <= byte_cnt[7:0];
						default: O_MEM_WDATA <= byte_cnt[15:8];
					endcase
					hdr_idx <= hdr_idx + 2'h1;
					if (hdr_idx == FCS_LAST) begin
						dma <= {next_page, 8'h00}; // [RULE24]
						rx_state <= RX_IDLE;
					end
				end
				default: rx_state <= RX_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Transmit path: check value appended after the last data byte
	assign out_free = !O_TX_VALID || I_TX_OUT_READY;
	// A stop only blocks the next frame; one already started runs out
	assign O_TX_READY = tx_state == TX_PASS && out_free
		&& (!tx_first || (tx_go && !halted && !tx_done)); // [RULE17]
	assign tx_take = I_TX_VALID && O_TX_READY;
	assign fcs = ~tx_crc;

	rbrm_crc32 u_tx_crc (
		.i_clk(I_CLK_SYS),
		.i_arst_n(I_ARST_N),
		.i_en(tx_take),
		.i_init(tx_first),
		.i_data(I_TX_DATA),
		.o_next(),
		.o_crc(tx_crc)
	);

	always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			tx_state <= TX_PASS;
			tx_first <= 1'b1;
			tx_done <= 1'b0;
			fcs_idx <= 2'h0;
			O_TX_VALID <= 1'b0;
			O_TX_LAST <= 1'b0;
			O_TX_DATA <= 8'h00;
		end else begin
			tx_done <= 1'b0;
			case (tx_state)
				TX_PASS: begin
					if (tx_take) begin
						O_TX_VALID <= 1'b1;
						O_TX_LAST <= 1'b0;
						O_TX_DATA <= I_TX_DATA;
						tx_first <= I_TX_LAST;
						fcs_idx <= 2'h0;
						if (I_TX_LAST) begin
							tx_state <= TX_FCS;
						end
					end else if (I_TX_OUT_READY) begin
						O_TX_VALID <= 1'b0;
					end
				end
				TX_FCS: begin
					if (out_free) begin
						O_TX_VALID <= 1'b1;
						O_TX_DATA <= fcs[8*fcs_idx +: 8]; // [RULE3]
						O_TX_LAST <= fcs_idx == FCS_LAST;
						fcs_idx <= fcs_idx + 2'h1;
						if (fcs_idx == FCS_LAST) begin
							tx_done <= 1'b1;
							tx_state <= TX_PASS;
						end
					end
				end
				default: tx_state <= TX_PASS;
			endcase
		end
	end
endmodule : rbrm_ring_manager
`default_nettype wire

// *** testbench/rbrm_buffer_ram.sv ***
// Behavioural local buffer RAM behind the ring manager write port.
// Assumes at most one byte write per clock; the bench peeks the array.
`timescale 1ns/10ps
`default_nettype none
module rbrm_buffer_ram (
	input wire logic i_clk,
	input wire logic i_we,
	input wire logic [15:0] i_addr,
	input wire logic [7:0] i_data
);
	// Whole 64k space; unwritten bytes stay unknown so stale data never matches
	logic [7:0] mem [0:65535];
	always_ff @(posedge i_clk) begin
		if (i_we) begin
			mem[i_addr] <= i_data;
		end
	end
endmodule : rbrm_buffer_ram
`default_nettype wire

// *** testbench/rbrm_ring_asserts.sv ***
// Port checks for the receive buffer ring manager.
// Assumes it is bound onto rbrm_ring_manager; single clock domain.
`timescale 1ns/10ps
`default_nettype none
module rbrm_ring_asserts (
	input wire logic I_CLK_SYS,
	input wire logic I_ARST_N,
	input wire logic I_AXI_ARVALID,
	input wire logic O_AXI_ARREADY,
	input wire logic O_AXI_RVALID,
	input wire logic O_AXI_BVALID,
	input wire logic I_AXI_BREADY,
	input wire logic [1:0] O_AXI_BRESP,
	input wire logic I_RX_VALID,
	input wire logic I_RX_SOF,
	input wire logic I_RX_LAST,
	input wire logic [7:0] I_RX_DATA,
	input wire logic O_MEM_WE,
	input wire logic [15:0] O_MEM_ADDR,
	input wire logic [7:0] O_MEM_WDATA,
	input wire logic I_TX_VALID,
	input wire logic I_TX_LAST,
	input wire logic O_TX_READY,
	input wire logic O_TX_VALID,
	input wire logic O_TX_LAST,
	input wire logic I_TX_OUT_READY
);
	default clocking @(posedge I_CLK_SYS); endclocking
	default disable iff (!I_ARST_N);
	////////////////////////////////////////////////////////////////////////
	rx_pass_a: assert property (O_MEM_WE && $past(I_RX_VALID) |-> O_MEM_WDATA == $past(I_RX_DATA))
		else $error("stored byte differs");
	hdr_gap_a: assert property (O_MEM_WE && $past(I_RX_VALID && I_RX_SOF) |-> O_MEM_ADDR[7:0] == 8'h04)
		else $error("first byte not at offset 4");
	addr_step_a: assert property (O_MEM_WE && $past(O_MEM_WE) && $past(I_RX_VALID) && $past(I_RX_VALID, 2)
		&& $past(O_MEM_ADDR[7:0]) != 8'hFF |-> O_MEM_ADDR == $past(O_MEM_ADDR) + 16'h1)
		else $error("address did not step");
	page_link_a: assert property (O_MEM_WE && $past(O_MEM_WE) && $past(I_RX_VALID) && $past(I_RX_VALID, 2)
		&& $past(O_MEM_ADDR[7:0]) == 8'hFF |-> O_MEM_ADDR[7:0] == 8'h00)
		else $error("link not at page start");
	hdr_write_a: assert property ($past(I_RX_VALID && I_RX_LAST) && O_MEM_WE ##1 O_MEM_WE |->
		O_MEM_ADDR[7:0] == 8'h00 ##1 O_MEM_ADDR[7:0] == 8'h01 ##1 O_MEM_ADDR[7:0] == 8'h02)
		else $error("header order wrong");
	fcs_tail_a: assert property (I_TX_VALID && O_TX_READY && I_TX_LAST && I_TX_OUT_READY |=>
		O_TX_VALID && !O_TX_LAST ##1 (O_TX_VALID && !O_TX_LAST)[*3] ##1 O_TX_VALID && O_TX_LAST)
		else $error("check bytes missing");
	fcs_block_a: assert property (O_TX_VALID && O_TX_LAST |-> !O_TX_READY)
		else $error("ready during check bytes");
	rd_answer_a: assert property (I_AXI_ARVALID && O_AXI_ARREADY |=> O_AXI_RVALID)
		else $error("read not answered");
	b_hold_a: assert property (O_AXI_BVALID && !I_AXI_BREADY |=> O_AXI_BVALID && $stable(O_AXI_BRESP))
		else $error("write response dropped");
endmodule : rbrm_ring_asserts
bind rbrm_ring_manager rbrm_ring_asserts rbrm_ring_asserts_i (.I_CLK_SYS(I_CLK_SYS),
	.I_ARST_N(I_ARST_N), .I_AXI_ARVALID(I_AXI_ARVALID), .O_AXI_ARREADY(O_AXI_ARREADY),
	.O_AXI_RVALID(O_AXI_RVALID), .O_AXI_BVALID(O_AXI_BVALID), .I_AXI_BREADY(I_AXI_BREADY),
	.O_AXI_BRESP(O_AXI_BRESP), .I_RX_VALID(I_RX_VALID), .I_RX_SOF(I_RX_SOF),
	.I_RX_LAST(I_RX_LAST), .I_RX_DATA(I_RX_DATA), .O_MEM_WE(O_MEM_WE), .O_MEM_ADDR(O_MEM_ADDR),
	.O_MEM_WDATA(O_MEM_WDATA), .I_TX_VALID(I_TX_VALID), .I_TX_LAST(I_TX_LAST),
	.O_TX_READY(O_TX_READY), .O_TX_VALID(O_TX_VALID), .O_TX_LAST(O_TX_LAST),
	.I_TX_OUT_READY(I_TX_OUT_READY));
`default_nettype wire

// *** testbench/rbrm_ring_manager_test.sv ***
// Self-checking bench: the bench plays host driver and MAC streams.
// Assumes the buffer RAM model and the bound checker; ring is pages 01..03.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin failures++; $display("[FAIL] %0t value mismatch", $time); end end
module rbrm_ring_manager_test import rbrm_pkg::*; ;
	logic clk = 0, arst_n = 0, awvalid = 0, wvalid = 0, arvalid = 0, rx_valid = 0, rx_sof = 0;
	logic rx_last = 0, tx_valid = 0, tx_last = 0, bready = 0, rready = 1, rx_align = 0;
	logic [7:0] awaddr = 0, araddr = 0, rx_data = 0, tx_data = 0, d, mem_wdata, txo_data;
	logic [31:0] wdata = 0, rdata;
	logic [1:0] r, bresp, rresp;
	logic [15:0] mem_addr;
	logic awready, wready, bvalid, arready, rvalid, mem_we, tx_ready, txo_valid, txo_last, go;
	logic [7:0] fr [0:1023];
	logic [7:0] txq [$];
	int failures = 0, checks = 0, cyc = 0, m;
	always #10 clk = ~clk;
	rbrm_ring_manager rbrm_ring_manager_i (.I_CLK_SYS(clk), .I_ARST_N(arst_n),
		.I_AXI_AWVALID(awvalid), .O_AXI_AWREADY(awready), .I_AXI_AWADDR(awaddr),
		.I_AXI_WVALID(wvalid), .O_AXI_WREADY(wready), .I_AXI_WDATA(wdata), .I_AXI_WSTRB(4'h1),
		.O_AXI_BVALID(bvalid), .I_AXI_BREADY(bready), .O_AXI_BRESP(bresp),
		.I_AXI_ARVALID(arvalid), .O_AXI_ARREADY(arready), .I_AXI_ARADDR(araddr),
		.O_AXI_RVALID(rvalid), .I_AXI_RREADY(rready), .O_AXI_RDATA(rdata), .O_AXI_RRESP(rresp),
		.I_RX_VALID(rx_valid), .I_RX_SOF(rx_sof), .I_RX_LAST(rx_last), .I_RX_ALIGN_ERR(rx_align),
		.I_RX_DATA(rx_data), .O_MEM_WE(mem_we), .O_MEM_ADDR(mem_addr), .O_MEM_WDATA(mem_wdata),
		.I_TX_VALID(tx_valid), .I_TX_LAST(tx_last), .I_TX_DATA(tx_data), .O_TX_READY(tx_ready),
		.O_TX_VALID(txo_valid), .O_TX_LAST(txo_last), .O_TX_DATA(txo_data), .I_TX_OUT_READY(1'b1));
	rbrm_buffer_ram rbrm_buffer_ram_i (.i_clk(clk), .i_we(mem_we), .i_addr(mem_addr),
		.i_data(mem_wdata));
	always @(posedge clk) begin
		if (txo_valid === 1'b1) txq.push_back(txo_data);
		cyc++;
		// Ceiling covers the 80000-cycle stop wait plus traffic
		if (cyc == 90000) begin
			failures++;
			report_and_stop();
		end
	end
	////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] crc8(input logic [31:0] c, input logic [7:0] b);
		logic [31:0] x;
		x = c ^ {24'h0, b};
		for (int k = 0; k < 8; k++) x = x[0] ? (x >> 1) ^ CRC_POLY : x >> 1;
		return x;
	endfunction : crc8
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		logic aw, w;
		aw = 1;
		w = 1;
		awaddr <= a;
		wdata <= {24'h0, v};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(posedge clk);
			if (aw && awready) begin aw = 0; awvalid <= 1'b0; end
			if (w && wready) begin w = 0; wvalid <= 1'b0; end
		end while (aw || w);
		// Late bready makes the slave hold its response
		repeat (2) @(posedge clk);
		bready <= 1'b1;
		do @(posedge clk); while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
		@(posedge clk);
	endtask : wr
	task automatic rd(input logic [7:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge clk); while (rvalid !== 1'b1);
		d = rdata[7:0];
		r = rresp;
		@(posedge clk);
	endtask : rd
	task automatic rx(input int n, input bit bad);
		logic [31:0] c;
		c = CRC_INIT;
		for (int i = 0; i < n - 4; i++) begin
			fr[i] = 8'(i * 7 + 3);
			c = crc8(c, fr[i]);
		end
		for (int i = 0; i < 4; i++) fr[n - 4 + i] = 8'(~(c >> (8 * i)));
		if (bad) fr[n - 1] = ~fr[n - 1];
		for (int i = 0; i < n; i++) begin
			rx_valid <= 1'b1;
			rx_sof <= (i == 0);
			rx_last <= (i == n - 1);
			rx_data <= fr[i];
			@(posedge clk);
		end
		rx_valid <= 1'b0;
		rx_last <= 1'b0;
		repeat (8) @(posedge clk);
	endtask : rx
	task automatic chk_frame(input logic [15:0] base, input int n);
		for (int i = 0; i < n; i++) `CHK(rbrm_buffer_ram_i.mem[base + 16'(i)], fr[i])
	endtask : chk_frame
	////////////////////////////////////////////////////////////////////////
	task automatic t_reset_map();
		rd(REG_CMD);
		`CHK(d, {7'h0, RST_HALTED})
		rd(8'h3C);
		`CHK(r, AXI_SLVERR)
		wr(8'h3C, 8'h5A);
		`CHK(r, AXI_SLVERR)
		wr(REG_FIRST, 8'h01);
		wr(REG_END, 8'h04);
		wr(REG_BNDRY, 8'h01);
		wr(REG_CURR, 8'h01);
		wr(REG_CMD, 8'h22);
	endtask : t_reset_map
	task automatic t_good();
		rx(100, 0);
		chk_frame(16'h0104, 100);
		`CHK(rbrm_buffer_ram_i.mem[16'h0100], 8'h01)
		`CHK(rbrm_buffer_ram_i.mem[16'h0101], 8'h02)
		`CHK(rbrm_buffer_ram_i.mem[16'h0102], 8'h64)
		`CHK(rbrm_buffer_ram_i.mem[16'h0103], 8'h00)
		rd(REG_CURR);
		`CHK(d, 8'h02)
	endtask : t_good
	task automatic t_reject_wrap();
		rx(80, 1);
		rd(REG_CURR);
		`CHK(d, 8'h02)
		rd(REG_EVENT);
		`CHK(d[EV_RX_ERR], 1'b1)
		rx_align <= 1'b1;
		rx(70, 0);
		rx_align <= 1'b0;
		rx(40, 0);
		rd(REG_CURR);
		`CHK(d, 8'h02)
		rx(300, 0);
		chk_frame(16'h0204, 300);
		`CHK(rbrm_buffer_ram_i.mem[16'h0201], 8'h01)
		rd(REG_CURR);
		`CHK(d, 8'h01)
	endtask : t_reject_wrap
	task automatic t_overflow();
		wr(REG_BNDRY, 8'h02);
		rx(600, 0);
		rd(REG_EVENT);
		`CHK(d[EV_OVF], 1'b1)
		`CHK(rbrm_buffer_ram_i.mem[16'h0204], 8'h03)
		rd(REG_MISSED);
		m = d;
		wr(REG_BNDRY, 8'h03);
		rx(70, 0);
		rd(REG_MISSED);
		`CHK(d, 8'(m + 1))
		rd(REG_CURR);
		`CHK(d, 8'h01)
	endtask : t_overflow
	task automatic t_recover();
		rd(REG_CMD);
		go = d[CMD_TX_GO];
		wr(REG_CMD, 8'h21);
		repeat (80000) @(posedge clk);
		rd(REG_MISSED);
		m = d;
		rx(70, 0);
		rd(REG_MISSED);
		`CHK(d, 8'(m))
		wr(REG_RCNT_LO, 8'h00);
		wr(REG_RCNT_HI, 8'h00);
		wr(REG_TXCFG, 8'h02);
		wr(REG_CMD, 8'h22);
		wr(REG_EVENT, 8'h10);
		rd(REG_EVENT);
		`CHK(d[EV_OVF], 1'b0)
		wr(REG_TXCFG, 8'h00);
		`CHK(go, 1'b0)
		rx(70, 0);
		chk_frame(16'h0104, 70);
		rd(REG_CURR);
		`CHK(d, 8'h02)
	endtask : t_recover
	task automatic t_tx();
		logic [31:0] c;
		c = CRC_INIT;
		wr(REG_CMD, 8'h26);
		for (int i = 0; i < 4; i++) begin
			tx_valid <= 1'b1;
			tx_data <= 8'(8'hA0 + i);
			tx_last <= (i == 3);
			c = crc8(c, 8'(8'hA0 + i));
			do @(posedge clk); while (tx_ready !== 1'b1);
		end
		tx_valid <= 1'b0;
		repeat (10) @(posedge clk);
		`CHK(txq.size(), 8)
		for (int i = 0; i < 4; i++) `CHK(txq[4 + i], 8'(~(c >> (8 * i))))
		rd(REG_EVENT);
		`CHK(d[EV_FRAME_SENT], 1'b1)
	endtask : t_tx
	////////////////////////////////////////////////////////////////////////
	task automatic report_and_stop();
		$display("failures=%0d checks=%0d", failures, checks);
		if (failures == 0 && checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : report_and_stop
	initial begin
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		t_reset_map();
		t_good();
		t_reject_wrap();
		t_overflow();
		t_recover();
		t_tx();
		report_and_stop();
	end
endmodule : rbrm_ring_manager_test
`default_nettype wire
